// file: dds_device_end.sv
`include "dds_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dds_device_end
    import dds_pkg::*;
#(
    parameter int NUM_REGS = 4,
    parameter int DATA_W   = `DDS_DATA_W,
    parameter int LATENCY  = `DDS_UPD_LATENCY
) (
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    dds_link_if.device             link,
    input  wire logic              three_wire_in,
    input  wire logic              reference_input_in,
    output logic                   osc_enable_out,
    output logic                   ref_pass_out,
    output logic      [DATA_W-1:0] ctrl_word_out,
    output logic      [DATA_W-1:0] freq_word_out,
    output logic                   ramp_up_out,
    output logic                   ramp_down_out,
    output logic                   full_sleep_out,
    output logic                   rapid_pd_out
);
    localparam int LAT_W = $clog2(LATENCY + 1);
    localparam int AW    = `DDS_ADDR_W;

    // Serial frame state, cleared whenever the frame ends or aborts
    typedef struct packed {
        logic [5:0]        cnt;
        logic [7:0]        instr;
        logic [DATA_W-1:0] data;
    } frame_t;

    // Words handed to the core domain; survives frame end
    typedef struct packed {
        logic              wr_tgl;
        logic              rd_tgl;
        logic [AW-1:0]     wr_addr;
        logic [AW-1:0]     rd_addr;
        logic [DATA_W-1:0] wr_data;
    } hand_t;

    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_W-1:0] buf_mem;
        logic [NUM_REGS-1:0][DATA_W-1:0] act;
        logic [DATA_W-1:0]               rd_word;
        logic [DATA_W-1:0]               pend;
        logic [DATA_W-1:0]               freq;
        logic [LAT_W-1:0]                lat;
        logic [1:0]                      div;
        logic                            sync_clk;
        logic                            wr_seen;
        logic                            rd_seen;
        logic                            upd_prev;
        logic                            follow_prev;
        logic                            osc_en;
        logic                            ramp_up;
        logic                            ramp_down;
        logic                            full_sleep;
        logic                            rapid_pd;
    } core_t;

    frame_t fr_r;
    frame_t fr_nxt;
    hand_t  hd_r;
    hand_t  hd_nxt;
    core_t  co_r;
    core_t  co_nxt;

    logic       fr_reset;
    logic       sdi;
    logic       rd_phase;
    logic [7:0] instr_done;
    logic [6:0] pins_s;
    logic       wr_tgl_s;
    logic       rd_tgl_s;
    logic       upd_s;
    logic       osc_s;
    logic       pd_s;
    logic       key_s;
    logic       follow_s;
    logic       tick;
    logic       osk_en;

    // MSB-first shift of one serial bit into a word
    function automatic logic [DATA_W-1:0] shift_in(
        input logic [DATA_W-1:0] w,
        input logic              b
    );
        shift_in = {w[DATA_W-2:0], b};
    endfunction

    // Register index check shared by read and write paths
    function automatic logic in_map(input logic [AW-1:0] a);
        in_map = (32'(a) < NUM_REGS);
    endfunction

    // ---------------- Link side, clocked by the serial clock
    // Select high or abort high holds the frame in reset, so a
    // new frame always opens at its first instruction bit.
    assign fr_reset = reset_in | link.serial_port_abort |
                      link.cs_n;
    assign sdi        = link.serial_data;
    assign instr_done = {fr_r.instr[6:0], sdi};
    assign rd_phase   = fr_r.instr[`DDS_READ_BIT] &&
                        (fr_r.cnt >= `DDS_CMD_BITS) &&
                        (fr_r.cnt < `DDS_TOTAL_BITS);

    // Instruction byte, then data word, sampled on rising edges
    always_comb begin
        fr_nxt = fr_r;
        hd_nxt = hd_r;
        if (fr_r.cnt < `DDS_TOTAL_BITS) begin
            fr_nxt.cnt = fr_r.cnt + 6'h01;
        end
        if (fr_r.cnt < `DDS_CMD_BITS) begin
            fr_nxt.instr = instr_done;
        end else if (fr_r.cnt < `DDS_TOTAL_BITS) begin
            fr_nxt.data = shift_in(fr_r.data, sdi);
        end
        // Read request leaves as soon as the instruction is in
        if ((fr_r.cnt == `DDS_CMD_BITS - 6'h01) &&
            instr_done[`DDS_READ_BIT]) begin
            hd_nxt.rd_tgl  = ~hd_r.rd_tgl;
            hd_nxt.rd_addr = instr_done[AW-1:0];
        end
        // A write hands over only when its last bit has arrived
        if ((fr_r.cnt == `DDS_TOTAL_BITS - 6'h01) &&
            !fr_r.instr[`DDS_READ_BIT]) begin
            hd_nxt.wr_tgl  = ~hd_r.wr_tgl;
            hd_nxt.wr_addr = fr_r.instr[AW-1:0];
            hd_nxt.wr_data = shift_in(fr_r.data, sdi);
        end
    end

    always_ff @(posedge link.sclk or posedge fr_reset) begin
        if (fr_reset) begin
            fr_r <= '0;
        end else begin
            fr_r <= fr_nxt;
        end
    end

    // Abort must not flip the toggles, or the core sees a phantom
    always_ff @(posedge link.sclk or posedge reset_in) begin
        if (reset_in) begin
            hd_r <= '0;
        end else begin
            hd_r <= hd_nxt;
        end
    end

    // Read bits come from the word the core captured during the
    // host's pause after the instruction byte.
    always_comb begin
        link.serial_read_out = 1'b0;
        link.d_data_o        = 1'b0;
        link.d_data_oe       = 1'b0;
        if (rd_phase) begin
            if (three_wire_in) begin
                link.serial_read_out = co_r.rd_word[
                    DATA_W - 1 - 32'(fr_r.cnt - `DDS_CMD_BITS)];
            end else begin
                link.d_data_o  = co_r.rd_word[
                    DATA_W - 1 - 32'(fr_r.cnt - `DDS_CMD_BITS)];
                link.d_data_oe = 1'b1;
            end
        end
    end

    // ---------------- Core side, clocked by the system clock
    dds_sync2 #(
        .W (7)
    ) u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .d_in     ({hd_r.wr_tgl, hd_r.rd_tgl, link.update_strobe,
                    link.oscillator_select, link.external_power_down,
                    link.keying_direction, link.sync_follow}),
        .q_out    ({wr_tgl_s, rd_tgl_s, upd_s, osc_s, pd_s, key_s,
                    follow_s})
    );

    assign osk_en = co_r.act[`DDS_REG_CTRL][`DDS_CTRL_OSK_EN];
    assign tick   = (co_r.div == `DDS_SYNC_LAST);

    always_comb begin
        co_nxt = co_r;
        // Quarter-rate sync clock; a master edge can realign it
        co_nxt.div         = co_r.div + 2'h1;
        co_nxt.follow_prev = follow_s;
        if (co_r.act[`DDS_REG_CTRL][`DDS_CTRL_SLAVE] &&
            follow_s && !co_r.follow_prev) begin
            co_nxt.div = 2'h0;
        end
        co_nxt.sync_clk = (co_nxt.div < `DDS_SYNC_HIGH);
        // Word handover: toggles synchronised, words already stable
        co_nxt.wr_seen = wr_tgl_s;
        co_nxt.rd_seen = rd_tgl_s;
        if ((wr_tgl_s != co_r.wr_seen) && in_map(hd_r.wr_addr)) begin
            co_nxt.buf_mem[hd_r.wr_addr] = hd_r.wr_data;
        end
        if (rd_tgl_s != co_r.rd_seen) begin
            co_nxt.rd_word = in_map(hd_r.rd_addr) ?
                             co_r.act[hd_r.rd_addr] : '0;
        end
        // Frequency pipeline delay after an update
        if (co_r.lat != '0) begin
            co_nxt.lat = co_r.lat - LAT_W'(1);
            if (co_r.lat == LAT_W'(1)) begin
                co_nxt.freq = co_r.pend;
            end
        end
        // Strobe looked at only on sync clock rising edges
        if (tick) begin
            co_nxt.upd_prev = upd_s;
            if (upd_s && !co_r.upd_prev) begin
                co_nxt.act  = co_r.buf_mem;
                co_nxt.pend = co_r.buf_mem[`DDS_REG_FREQ];
                co_nxt.lat  = LAT_W'(LATENCY);
            end
        end
        co_nxt.osc_en     = osc_s;
        co_nxt.ramp_up    = osk_en & key_s;
        co_nxt.ramp_down  = osk_en & ~key_s;
        co_nxt.full_sleep = pd_s &
                            co_r.act[`DDS_REG_CTRL][`DDS_CTRL_PD_FULL];
        co_nxt.rapid_pd   = pd_s &
                            ~co_r.act[`DDS_REG_CTRL][`DDS_CTRL_PD_FULL];
    end

    // Hardware reset clears buffer and active registers alike
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            co_r <= '0;
            co_r.sync_clk <= 1'b1; // Divider restarts in its high phase
        end else begin
            co_r <= co_nxt;
        end
    end

    // Outputs driven from core flops; ref_pass_out also gated by reference_input_in
    assign link.sync_clk   = co_r.sync_clk;
    assign osc_enable_out  = co_r.osc_en;
    assign ref_pass_out    = reference_input_in & ~co_r.osc_en;
    assign ctrl_word_out   = co_r.act[`DDS_REG_CTRL];
    assign freq_word_out   = co_r.freq;
    assign ramp_up_out     = co_r.ramp_up;
    assign ramp_down_out   = co_r.ramp_down;
    assign full_sleep_out  = co_r.full_sleep;
    assign rapid_pd_out    = co_r.rapid_pd;
endmodule

`default_nettype wire

// file: dds_host_end.sv
`include "dds_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dds_host_end
    import dds_pkg::*;
#(
    parameter int DATA_W = `DDS_DATA_W
) (
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    dds_link_if.host                    link,
    input  wire logic                   three_wire_in,
    input  wire logic                   req_valid_in,
    output logic                        req_ready_out,
    input  wire logic                   req_read_in,
    input  wire logic [`DDS_ADDR_W-1:0] req_addr_in,
    input  wire logic      [DATA_W-1:0] req_data_in,
    output logic                        rsp_valid_out,
    output logic           [DATA_W-1:0] rsp_data_out,
    input  wire logic                   update_in,
    input  wire logic                   keying_in,
    input  wire logic                   abort_in,
    input  wire logic                   reset_req_in,
    input  wire logic                   osc_select_in,
    input  wire logic                   power_down_in
);
    typedef struct packed {
        host_state_t       st;
        logic [7:0]        tmr;
        logic [5:0]        nbit;
        logic [39:0]       sh;
        logic              rd;
        logic              rsp_valid;
        logic [DATA_W-1:0] rsp_data;
        logic              sclk;
        logic              cs_n;
        logic              oe;
        logic              upd_pend;
        logic              upd;
        logic              key;
        logic              sync_prev;
        logic [2:0]        rst_cnt;
        logic              abort;
        logic              osc;
        logic              pd;
    } host_t;

    host_t h_r;
    host_t h_nxt;
    logic  data_s;
    logic  rdo_s;
    logic  sync_s;
    logic  sync_rise;
    logic  rd_bit;

    dds_sync2 #(
        .W (3)
    ) u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .d_in     ({link.serial_data, link.serial_read_out,
                    link.sync_clk}),
        .q_out    ({data_s, rdo_s, sync_s})
    );

    assign sync_rise = sync_s & ~h_r.sync_prev;
    assign rd_bit    = three_wire_in ? rdo_s : data_s;

    always_comb begin
        h_nxt           = h_r;
        h_nxt.rsp_valid = 1'b0;
        h_nxt.sync_prev = sync_s;
        h_nxt.abort     = abort_in;
        h_nxt.osc       = osc_select_in;
        h_nxt.pd        = power_down_in;
        // Strobe and keying change only on sync clock rises
        if (sync_rise) begin
            h_nxt.key = keying_in;
            h_nxt.upd = h_r.upd_pend;
            if (h_r.upd_pend) begin
                h_nxt.upd_pend = 1'b0;
            end
        end
        if (update_in) begin
            h_nxt.upd_pend = 1'b1;
        end
        // Reset pulse stretched to the device minimum
        if (reset_req_in) begin
            h_nxt.rst_cnt = 3'(`DDS_RST_MIN_CYC);
        end else if (h_r.rst_cnt != 3'h0) begin
            h_nxt.rst_cnt = h_r.rst_cnt - 3'h1;
        end
        if (h_r.tmr != 8'h00) begin
            h_nxt.tmr = h_r.tmr - 8'h01;
        end
        case (h_r.st)
            H_IDLE: begin
                if (req_valid_in && !h_r.abort && !abort_in) begin
                    h_nxt.st   = H_LOW;
                    h_nxt.cs_n = 1'b0;
                    h_nxt.sh   = {req_read_in, 2'b00, req_addr_in,
                                  req_data_in};
                    h_nxt.rd   = req_read_in;
                    h_nxt.nbit = 6'h00;
                    h_nxt.oe   = 1'b1;
                    h_nxt.tmr  = `DDS_SCLK_HALF - 8'h01;
                end
            end
            H_LOW: begin
                if (h_r.tmr == 8'h00) begin
                    h_nxt.sclk = 1'b1;
                    h_nxt.st   = H_HIGH;
                    h_nxt.tmr  = `DDS_SCLK_HALF - 8'h01;
                    if (h_r.rd && h_r.nbit >= `DDS_CMD_BITS) begin
                        h_nxt.rsp_data = {h_r.rsp_data[DATA_W-2:0],
                                          rd_bit};
                    end
                end
            end
            H_HIGH: begin
                if (h_r.tmr == 8'h00) begin
                    h_nxt.sclk = 1'b0;
                    h_nxt.nbit = h_r.nbit + 6'h01;
                    h_nxt.sh   = {h_r.sh[38:0], 1'b0};
                    h_nxt.tmr  = `DDS_SCLK_HALF - 8'h01;
                    h_nxt.st   = H_LOW;
                    if (h_r.nbit == `DDS_TOTAL_BITS - 6'h01) begin
                        h_nxt.st   = H_FINISH;
                        h_nxt.cs_n = 1'b1;
                        h_nxt.oe   = 1'b0;
                        h_nxt.tmr  = `DDS_WR_GAP;
                    end else if (h_r.rd &&
                        h_r.nbit == `DDS_CMD_BITS - 6'h01) begin
                        // Let go of the data pin, wait for the word
                        h_nxt.st  = H_GAP;
                        h_nxt.oe  = 1'b0;
                        h_nxt.tmr = `DDS_RD_GAP;
                    end
                end
            end
            H_GAP: begin
                if (h_r.tmr == 8'h00) begin
                    h_nxt.st  = H_LOW;
                    h_nxt.tmr = `DDS_SCLK_HALF - 8'h01;
                end
            end
            H_FINISH: begin
                if (h_r.tmr == 8'h00) begin
                    h_nxt.st        = H_IDLE;
                    h_nxt.rsp_valid = 1'b1;
                end
            end
            default: begin
                h_nxt.st = H_IDLE;
            end
        endcase
        // Abort drops the frame; a new one waits for release
        if (abort_in) begin
            h_nxt.st   = H_IDLE;
            h_nxt.cs_n = 1'b1;
            h_nxt.sclk = 1'b0;
            h_nxt.oe   = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            h_r      <= '0;
            h_r.cs_n <= 1'b1;
            h_r.st   <= H_IDLE;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign req_ready_out            = (h_r.st == H_IDLE) && !h_r.abort;
    assign rsp_valid_out            = h_r.rsp_valid;
    assign rsp_data_out             = h_r.rsp_data;
    assign link.sclk                = h_r.sclk;
    assign link.cs_n                = h_r.cs_n;
    assign link.h_data_o            = h_r.sh[39];
    assign link.h_data_oe           = h_r.oe;
    assign link.update_strobe       = h_r.upd;
    assign link.serial_port_abort   = h_r.abort;
    assign link.hw_reset            = (h_r.rst_cnt != 3'h0);
    assign link.oscillator_select   = h_r.osc;
    assign link.external_power_down = h_r.pd;
    assign link.keying_direction    = h_r.key;
endmodule

`default_nettype wire

// file: dds_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module dds_link_asserts (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic dev_clk_in,
    input wire logic dev_reset_in,
    input wire logic three_wire_in,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic h_data_oe,
    input wire logic d_data_oe,
    input wire logic serial_port_abort,
    input wire logic sync_clk,
    input wire logic sync_follow
);
    // Steps of the sync clock and of one serial bit
    sequence sync_tail_s;
        sync_clk ##1 !sync_clk ##1 !sync_clk ##1 sync_clk;
    endsequence
    sequence bit_low_s;
        !sclk [*4];
    endsequence
    sequence bit_high_s;
        sclk [*4];
    endsequence

    // A master edge realigns the divider; skip period checks nearby
    logic [2:0] follow_win_r;
    always_ff @(posedge dev_clk_in or posedge dev_reset_in) begin
        if (dev_reset_in) begin
            follow_win_r <= 3'h0;
        end else if (sync_follow) begin
            follow_win_r <= 3'h5;
        end else if (follow_win_r != 3'h0) begin
            follow_win_r <= follow_win_r - 3'h1;
        end
    end

    // Device side, sampled on the device clock
    AST_SYNC_PERIOD: assert property (@(posedge dev_clk_in)
        disable iff (dev_reset_in || (follow_win_r != 3'h0))
        $rose(sync_clk) |=> sync_tail_s)
        else $error("sync clock period wrong");
    AST_THREE_QUIET: assert property (@(posedge dev_clk_in)
        disable iff (dev_reset_in) three_wire_in |-> !d_data_oe)
        else $error("device drove data pin in three-wire mode");
    AST_DESELECT_QUIET: assert property (@(posedge dev_clk_in)
        disable iff (dev_reset_in) cs_n |-> !d_data_oe)
        else $error("device drove data pin while deselected");
    AST_ABORT_QUIET: assert property (@(posedge dev_clk_in)
        disable iff (dev_reset_in) serial_port_abort |-> !d_data_oe)
        else $error("device kept driving during abort");

    // Host side, sampled on the host clock
    AST_FRAME_START: assert property (@(posedge clk_in)
        disable iff (reset_in) $fell(cs_n) |-> bit_low_s ##1 bit_high_s)
        else $error("first bit of frame has wrong shape");
    AST_SCLK_HIGH: assert property (@(posedge clk_in)
        disable iff (reset_in) $rose(sclk) |-> bit_high_s ##1 !sclk)
        else $error("serial clock high phase wrong");
    AST_SCLK_IN_FRAME: assert property (@(posedge clk_in)
        disable iff (reset_in) sclk |-> !cs_n)
        else $error("serial clock high outside frame");
    AST_HOST_OE_FRAME: assert property (@(posedge clk_in)
        disable iff (reset_in) h_data_oe |-> !cs_n)
        else $error("host drove data pin outside frame");
endmodule

`default_nettype wire

// file: dds_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dds_link_if;
    logic sclk;
    logic cs_n;
    logic h_data_o;
    logic h_data_oe;
    logic d_data_o;
    logic d_data_oe;
    logic serial_data;
    logic serial_read_out;
    logic update_strobe;
    logic serial_port_abort;
    logic hw_reset;
    logic oscillator_select;
    logic external_power_down;
    logic keying_direction;
    logic sync_clk;
    logic sync_follow;

    // Shared data wire, weak pull-down when nobody drives
    assign serial_data = h_data_oe ? h_data_o :
                         (d_data_oe ? d_data_o : 1'b0);

    modport host (
        output sclk, cs_n, h_data_o, h_data_oe, update_strobe,
        output serial_port_abort, hw_reset, oscillator_select,
        output external_power_down, keying_direction,
        input  serial_data, serial_read_out, sync_clk
    );

    modport device (
        input  sclk, cs_n, serial_data, update_strobe,
        input  serial_port_abort, oscillator_select,
        input  external_power_down, keying_direction, sync_follow,
        output d_data_o, d_data_oe, serial_read_out, sync_clk
    );
endinterface

`default_nettype wire

// file: dds_params.svh
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH

// Serial frame layout: one instruction byte, then one data word
`define DDS_CMD_BITS      6'd8
`define DDS_TOTAL_BITS    6'd40
`define DDS_DATA_W        32
`define DDS_ADDR_W        5
`define DDS_READ_BIT      7

// Register indices inside the device
`define DDS_REG_CTRL      5'h00
`define DDS_REG_FREQ      5'h01

// Control register field positions
`define DDS_CTRL_OSK_EN   0
`define DDS_CTRL_SLAVE    1
`define DDS_CTRL_PD_FULL  2

// Sync clock is a quarter of the system clock
`define DDS_SYNC_LAST     2'h3
`define DDS_SYNC_HIGH     2'h2

// Timing counts in system clock cycles
`define DDS_UPD_LATENCY   24
`define DDS_RST_MIN_CYC   5
`define DDS_SCLK_HALF     8'h04
`define DDS_RD_GAP        8'h10
`define DDS_WR_GAP        8'h10

`endif

// file: dds_pkg.sv
package dds_pkg;

    typedef enum logic [2:0] {
        H_IDLE   = 3'b000,
        H_LOW    = 3'b001,
        H_HIGH   = 3'b010,
        H_GAP    = 3'b011,
        H_FINISH = 3'b100
    } host_state_t;

endpackage

// file: dds_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module dds_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    // First stage feeds only the second stage
    always_comb begin
        s_nxt.meta   = d_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.stable;
endmodule

`default_nettype wire

// file: test_dds_control_pin_interface.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    fail_count++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end end

module test_dds_control_pin_interface;
    logic        clk_in, dev_clk, reset_in, dev_reset, three_wire;
    logic        req_valid, req_read, req_ready, rsp_valid, update, keying;
    logic        abort, reset_req, osc_sel, pwr_dn, osc_en, ref_pass;
    logic        ramp_up, ramp_down, full_sleep, rapid_pd, follow;
    logic [4:0]  req_addr;
    logic [31:0] req_data, rsp_data, ctrl_word, freq_word, act, v;
    int          fail_count, checked, cycles;

    dds_link_if i_dds_link_if ();
    assign i_dds_link_if.sync_follow = follow;
    // Hardware reset from the host also clears the device
    assign dev_reset = reset_in | i_dds_link_if.hw_reset;

    dds_device_end i_dds_device_end (.clk_in(dev_clk), .reset_in(dev_reset),
        .link(i_dds_link_if.device), .three_wire_in(three_wire),
        .reference_input_in(1'b1), .osc_enable_out(osc_en),
        .ref_pass_out(ref_pass), .ctrl_word_out(ctrl_word),
        .freq_word_out(freq_word), .ramp_up_out(ramp_up),
        .ramp_down_out(ramp_down), .full_sleep_out(full_sleep),
        .rapid_pd_out(rapid_pd));
    dds_host_end i_dds_host_end (.clk_in(clk_in), .reset_in(reset_in),
        .link(i_dds_link_if.host), .three_wire_in(three_wire),
        .req_valid_in(req_valid), .req_ready_out(req_ready),
        .req_read_in(req_read), .req_addr_in(req_addr),
        .req_data_in(req_data), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .update_in(update), .keying_in(keying),
        .abort_in(abort), .reset_req_in(reset_req), .osc_select_in(osc_sel),
        .power_down_in(pwr_dn));
    dds_link_asserts i_dds_link_asserts (.clk_in(clk_in), .reset_in(reset_in),
        .dev_clk_in(dev_clk), .dev_reset_in(dev_reset),
        .three_wire_in(three_wire), .sclk(i_dds_link_if.sclk),
        .cs_n(i_dds_link_if.cs_n), .h_data_oe(i_dds_link_if.h_data_oe),
        .d_data_oe(i_dds_link_if.d_data_oe),
        .serial_port_abort(i_dds_link_if.serial_port_abort),
        .sync_clk(i_dds_link_if.sync_clk),
        .sync_follow(i_dds_link_if.sync_follow));

    // Device clock has its own phase and period so crossings get exercised
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        dev_clk = 1'b0;
        #7;
        forever #32 dev_clk = ~dev_clk;
    end

    task automatic complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs about 4500 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic idle(input int c);
        repeat (c) @(posedge clk_in);
        #5;
    endtask

    // One request; waiting for its answer is optional so aborts can hit
    task automatic xfer(input logic rd, input logic [4:0] a,
                        input logic [31:0] d, input bit wt);
        int n;
        req_read = rd;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) idle(1);
        idle(1);
        req_valid = 1'b0;
        n = 0;
        while (wt && rsp_valid !== 1'b1 && n < 3000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        #4;
        if (wt) `CHK(rsp_valid, 1'b1)
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        xfer(1'b1, a, 32'h0, 1'b1);
        `CHK(rsp_data, e)
    endtask

    // Old word must still stand well inside the latency window
    task automatic upd(input logic [31:0] old_w, input logic [31:0] new_w);
        update = 1'b1;
        idle(1);
        update = 1'b0;
        idle(24);
        `CHK(freq_word, old_w)
        idle(56);
        `CHK(freq_word, new_w)
    endtask

    // Master sync pulse: the sync clock must restart its high phase
    task automatic follow_pulse();
        @(posedge dev_clk);
        #5;
        follow = 1'b1;
        @(posedge dev_clk);
        #5;
        follow = 1'b0;
        repeat (2) @(posedge dev_clk);
        #1;
        `CHK(i_dds_link_if.sync_clk, 1'b1)
        repeat (2) @(posedge dev_clk);
        #1;
        `CHK(i_dds_link_if.sync_clk, 1'b0)
    endtask

    initial begin
        {req_valid, req_read, update, keying, abort, follow} = '0;
        {reset_req, osc_sel, pwr_dn, three_wire} = '0;
        req_addr = '0;
        req_data = '0;
        act = '0;
        reset_in = 1'b1;
        repeat (12) @(posedge clk_in);
        #5;
        reset_in = 1'b0;
        idle(2);
        for (int m = 0; m < 2; m++) begin
            three_wire = m[0];
            v = m[0] ? 32'h5A3CF0E1 : 32'hA5C30F1E;
            xfer(1'b0, 5'h01, v, 1'b1);
            rd(5'h01, act);
            rd(5'h1F, 32'h0);
            upd(act, v);
            act = v;
            rd(5'h01, act);
        end
        xfer(1'b0, 5'h00, 32'h00000007, 1'b1);
        upd(act, act);
        `CHK(ctrl_word, 32'h00000007)
        // Second pulse lands where a free-running divider would be low
        repeat (2) follow_pulse();
        idle(1);
        keying = 1'b1;
        pwr_dn = 1'b1;
        idle(20);
        `CHK({ramp_up, ramp_down, full_sleep, rapid_pd}, 4'hA)
        keying = 1'b0;
        pwr_dn = 1'b0;
        idle(20);
        `CHK({ramp_up, ramp_down, full_sleep, rapid_pd}, 4'h4)
        osc_sel = 1'b1;
        idle(10);
        `CHK({osc_en, ref_pass}, 2'h2)
        osc_sel = 1'b0;
        idle(10);
        `CHK({osc_en, ref_pass}, 2'h1)
        xfer(1'b0, 5'h01, 32'h0BADF00D, 1'b0);
        idle(100);
        abort = 1'b1;
        idle(3);
        `CHK(req_ready, 1'b0)
        abort = 1'b0;
        idle(20);
        upd(act, act);
        rd(5'h01, act);
        reset_req = 1'b1;
        idle(1);
        reset_req = 1'b0;
        idle(30);
        `CHK({freq_word, ctrl_word}, 64'h0)
        rd(5'h01, 32'h0);
        complete_run();
    end
endmodule

`default_nettype wire
